// >>> rtl/asp_top.sv
// Asynchronous serial port: rate generator, transmitter, receiver, flags
`timescale 1ns/10ps
module asp_top
    import asp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire asp_bus_t bus,
    output logic [7:0] rdata,
    input wire logic rx_line,
    output logic tx_line,
    output logic tx_interrupt,
    output logic rx_interrupt
);

    // ==========================================
    // State
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] per;
        logic [12:0] div_cnt;
        logic tbep;
        logic tend;
        logic rbfl;
        logic oerr;
        logic parity_error_flag;
        logic frame_error_flag;
        logic tx_arm;
        logic rx_arm;
        logic oerr_seen;
        logic [7:0] thold;
        logic tpend;
        asp_tx_st_t tx_st;
        logic [11:0] tx_frm;
        logic [3:0] tx_left;
        logic [3:0] tx_tk;
        asp_rx_st_t rx_st;
        logic [3:0] rx_tk;
        logic [2:0] rx_smp;
        logic [3:0] rx_n;
        logic [7:0] rx_d;
        logic rx_par;
        logic [7:0] rbuf;
        logic [7:0] rdata;
        logic tx_line;
        logic tx_int;
        logic rx_int;
    } asp_state_t;

    asp_state_t s_r;
    asp_state_t s_nxt;

    // ==========================================
    // Helpers
    function automatic logic [12:0] rate_div(input logic [2:0] code,
                                              input logic [7:0] per);
        begin
            if (code == RATE_TIMER) begin
                rate_div = (per == 8'h00) ? 13'h0001 : {5'h00, per};
            end else if (code <= RATE_SLOWEST) begin
                rate_div = TICK_DIV0 << code;
            end else begin
                rate_div = 13'h0000;
            end
        end
    endfunction

    function automatic logic maj3(input logic [2:0] v);
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    logic [2:0] rate_code;
    logic [12:0] div_val;
    logic tick;
    logic rx_v;
    logic [3:0] rx_stop_n;
    logic tx_par;

    assign rate_code = s_r.ctrl[CTL_RATE_LO +: 3];
    assign div_val = rate_div(rate_code, s_r.per);
    // Code 111 stops the rate generator, so nothing shifts
    assign tick = (div_val != 13'h0000) && (s_r.div_cnt >= div_val - 13'h0001);
    assign rx_v = maj3(s_r.rx_smp);
    assign rx_stop_n = s_r.ctrl[CTL_PEN] ? 4'ha : 4'h9;
    assign tx_par = s_r.ctrl[CTL_EVEN] ? ^s_r.thold : ~^s_r.thold;

    // ==========================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.tx_int = 1'b0;
        s_nxt.rx_int = 1'b0;

        // Oversample tick generator
        if (tick || div_val == 13'h0000) begin
            s_nxt.div_cnt = 13'h0000;
        end else begin
            s_nxt.div_cnt = s_r.div_cnt + 13'h0001;
        end

        // Bus: reads and their clearing side effects come before hardware
        // sets below, so an event in the clearing cycle is kept
        s_nxt.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                ADDR_CTRL: begin
                    s_nxt.rdata = s_r.ctrl;
                end
                ADDR_TPER: begin
                    s_nxt.rdata = s_r.per;
                end
                ADDR_STAT: begin
                    s_nxt.rdata = {s_r.parity_error_flag, s_r.frame_error_flag, s_r.oerr, s_r.rbfl,
                                   s_r.tend, s_r.tbep, 2'b00};
                    s_nxt.tx_arm = 1'b1;
                    s_nxt.rx_arm = 1'b1;
                    s_nxt.oerr_seen = s_r.oerr;
                end
                ADDR_BUF: begin
                    s_nxt.rdata = s_r.rbuf;
                    if (s_r.rx_arm) begin
                        s_nxt.rbfl = 1'b0;
                        s_nxt.parity_error_flag = 1'b0;
                        s_nxt.frame_error_flag = 1'b0;
                        if (s_r.oerr_seen) begin
                            s_nxt.oerr = 1'b0;
                        end
                    end
                    s_nxt.rx_arm = 1'b0;
                end
                default: begin
                    s_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Transmitter
        case (s_r.tx_st)
            ASP_TX_IDLE: begin
                s_nxt.tx_line = 1'b1;
                if (s_r.tpend && s_r.ctrl[CTL_TXE] && tick) begin
                    if (s_r.ctrl[CTL_PEN]) begin
                        s_nxt.tx_frm = {2'b11, tx_par, s_r.thold, 1'b0};
                    end else begin
                        s_nxt.tx_frm = {3'b111, s_r.thold, 1'b0};
                    end
                    s_nxt.tx_left = 4'ha + {3'b000, s_r.ctrl[CTL_PEN]}
                        + {3'b000, s_r.ctrl[CTL_STOP2]};
                    s_nxt.tx_tk = 4'h0;
                    s_nxt.tx_line = 1'b0;
                    s_nxt.tpend = 1'b0;
                    s_nxt.tbep = 1'b1;
                    s_nxt.tx_int = 1'b1;
                    s_nxt.tend = 1'b0;
                    s_nxt.tx_st = ASP_TX_SEND;
                end
            end
            ASP_TX_SEND: begin
                if (tick) begin
                    s_nxt.tx_tk = s_r.tx_tk + 4'h1;
                    if (s_r.tx_tk == TICK_LAST) begin
                        s_nxt.tx_frm = {1'b1, s_r.tx_frm[11:1]};
                        s_nxt.tx_left = s_r.tx_left - 4'h1;
                        s_nxt.tx_line = s_r.tx_frm[1];
                        if (s_r.tx_left == 4'h1) begin
                            s_nxt.tx_line = 1'b1;
                            s_nxt.tx_st = ASP_TX_IDLE;
                            if (!s_r.tpend) begin
                                s_nxt.tend = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                s_nxt.tx_st = ASP_TX_IDLE;
            end
        endcase

        // Receiver
        case (s_r.rx_st)
            ASP_RX_IDLE: begin
                // Enable is only looked at here, so a disable waits for frame end
                if (tick && !rx_line && s_r.ctrl[CTL_RXE] && !s_r.oerr) begin
                    s_nxt.rx_st = ASP_RX_BITS;
                    s_nxt.rx_tk = 4'h1;
                    s_nxt.rx_n = 4'h0;
                end
            end
            ASP_RX_BITS: begin
                if (tick) begin
                    s_nxt.rx_tk = s_r.rx_tk + 4'h1;
                    if (s_r.rx_tk >= SMP_FIRST && s_r.rx_tk <= SMP_LAST) begin
                        s_nxt.rx_smp = {s_r.rx_smp[1:0], rx_line};
                    end
                    if (s_r.rx_tk == TICK_LAST) begin
                        s_nxt.rx_n = s_r.rx_n + 4'h1;
                        if (s_r.rx_n == 4'h0) begin
                            // A glitch that votes high is not a start bit
                            if (rx_v) begin
                                s_nxt.rx_st = ASP_RX_IDLE;
                            end
                        end else if (s_r.rx_n <= 4'h8) begin
                            s_nxt.rx_d = {rx_v, s_r.rx_d[7:1]};
                        end else if (s_r.rx_n < rx_stop_n) begin
                            s_nxt.rx_par = rx_v;
                        end else begin
                            s_nxt.rx_st = ASP_RX_IDLE;
                            if (!rx_v) begin
                                s_nxt.frame_error_flag = 1'b1;
                            end
                            if (s_r.rbfl) begin
                                s_nxt.oerr = 1'b1;
                            end else begin
                                s_nxt.rbuf = s_r.rx_d;
                                s_nxt.rbfl = 1'b1;
                                s_nxt.rx_int = 1'b1;
                                if (s_r.ctrl[CTL_PEN] && s_r.rx_par !=
                                    (s_r.ctrl[CTL_EVEN] ? ^s_r.rx_d : ~^s_r.rx_d)) begin
                                    s_nxt.parity_error_flag = 1'b1;
                                end
                            end
                        end
                    end
                end
            end
            default: begin
                s_nxt.rx_st = ASP_RX_IDLE;
            end
        endcase

        // Bus writes; a byte written after a status read with the transmitter enabled makes the holding buffer full again
        if (bus.wr) begin
            case (bus.addr)
                ADDR_CTRL: begin
                    s_nxt.ctrl = bus.wdata;
                end
                ADDR_TPER: begin
                    s_nxt.per = bus.wdata;
                end
                ADDR_BUF: begin
                    if (s_r.tx_arm && s_r.ctrl[CTL_TXE]) begin
                        s_nxt.thold = bus.wdata;
                        s_nxt.tpend = 1'b1;
                        s_nxt.tbep = 1'b0;
                    end
                    s_nxt.tx_arm = 1'b0;
                end
                default: begin
                    s_nxt.tx_arm = s_nxt.tx_arm;
                end
            endcase
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.ctrl <= CTRL_RST;
            s_r.per <= TPER_RST;
            s_r.tbep <= 1'b1;
            s_r.tend <= 1'b1;
            s_r.tx_line <= 1'b1;
            s_r.tx_frm <= 12'hfff;
            s_r.tx_st <= ASP_TX_IDLE;
            s_r.rx_st <= ASP_RX_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign tx_line = s_r.tx_line;
    assign tx_interrupt = s_r.tx_int;
    assign rx_interrupt = s_r.rx_int;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    AST_TX_IDLE_HIGH: assert property (
        (s_r.tx_st == ASP_TX_IDLE) ##1 (s_nxt.tx_st == ASP_TX_IDLE) |-> tx_line)
        else $error("Transmit line low while transmitter idle");
    AST_TX_START_LOW: assert property (
        (s_r.tx_st == ASP_TX_IDLE) ##1 (s_r.tx_st == ASP_TX_SEND) |->
        !tx_line && tx_interrupt)
        else $error("Frame start not low or no transmit interrupt");
    AST_TX_INT_CAUSE: assert property (
        tx_interrupt |-> $past(s_r.tpend) && !s_r.tend)
        else $error("Transmit interrupt without pending byte");
    AST_WR_ARMED: assert property (
        bus.wr && bus.addr == ADDR_BUF && s_r.tx_arm && s_r.ctrl[CTL_TXE]
        |=> s_r.tpend && !s_r.tbep)
        else $error("Armed buffer write did not load the byte");
    AST_WR_UNARMED: assert property (
        bus.wr && bus.addr == ADDR_BUF && !s_r.tx_arm |=> !$rose(s_r.tpend))
        else $error("Unarmed buffer write started a transfer");
    AST_RX_INT_FULL: assert property (
        rx_interrupt |-> s_r.rbfl && !$past(s_r.rbfl))
        else $error("Receive interrupt without full flag");
    AST_OVR_KEEP: assert property (
        $rose(s_r.oerr) |-> $stable(s_r.rbuf) && !rx_interrupt)
        else $error("Overrun changed the receive buffer");
    AST_OVR_BLOCK: assert property (
        s_r.oerr && s_r.rx_st == ASP_RX_IDLE |=> s_r.rx_st == ASP_RX_IDLE)
        else $error("Reception started during overrun");
    AST_RX_CLEAR: assert property (
        bus.rd && bus.addr == ADDR_BUF && s_r.rx_arm |=>
        !s_r.rbfl || rx_interrupt)
        else $error("Status then buffer read did not clear full flag");
    // Flag, line, sampling, buffer load and receive enable checks
    AST_TX_END_SET: assert property (
        (s_r.tx_st == ASP_TX_SEND) ##1 (s_r.tx_st == ASP_TX_IDLE) |-> s_r.tend || s_r.tpend)
        else $error("Frame ended with nothing pending but end flag clear");
    AST_TBEP_ON_START: assert property (
        tx_interrupt |-> s_r.tbep || s_r.tpend)
        else $error("Shift start left the buffer empty flag clear");
    AST_TX_STOP_HIGH: assert property (
        s_r.tx_st == ASP_TX_SEND && s_r.tx_left == 4'h1 |-> tx_line)
        else $error("Last stop bit not high");
    AST_TX_OFF_HIGH: assert property (
        s_r.tx_st == ASP_TX_IDLE && !s_r.ctrl[CTL_TXE] |=> tx_line)
        else $error("Transmit line low while transmit disabled");
    AST_RX_SAMPLE_WIN: assert property (
        $changed(s_r.rx_smp) |-> $past(s_r.rx_tk) >= SMP_FIRST && $past(s_r.rx_tk) <= SMP_LAST)
        else $error("Receive sample taken outside ticks 7 to 9");
    AST_RX_LOAD_DATA: assert property (
        rx_interrupt |-> s_r.rbuf == $past(s_r.rx_d))
        else $error("Receive buffer not loaded with the shifted byte");
    AST_PARITY_ERROR_FLAG_ON_LOAD: assert property (
        $rose(s_r.parity_error_flag) |-> rx_interrupt)
        else $error("Parity error flag set without a buffer load");
    AST_FRAME_ERROR_FLAG_AT_END: assert property (
        $rose(s_r.frame_error_flag) |-> $past(s_r.rx_st) == ASP_RX_BITS && s_r.rx_st == ASP_RX_IDLE)
        else $error("Framing error flag set outside frame end");
    AST_RX_OFF_IDLE: assert property (
        s_r.rx_st == ASP_RX_IDLE && !s_r.ctrl[CTL_RXE] |=> s_r.rx_st == ASP_RX_IDLE)
        else $error("Reception started while receive disabled");
    AST_OVR_LATE_KEEP: assert property (
        bus.rd && bus.addr == ADDR_BUF && s_r.oerr && !s_r.oerr_seen |=> s_r.oerr)
        else $error("Overrun not seen at status read was cleared");
endmodule

// >>> rtl/asp_pkg.sv
// Package: constants and types of the asynchronous serial port
package asp_pkg;
    // ==========================================
    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h20;
    localparam logic [7:0] ADDR_TPER = 8'h21;
    localparam logic [7:0] ADDR_STAT = 8'h22;
    localparam logic [7:0] ADDR_BUF = 8'h24;
    // ==========================================
    // Control field positions
    localparam int CTL_TXE = 0;
    localparam int CTL_RXE = 1;
    localparam int CTL_STOP2 = 2;
    localparam int CTL_PEN = 3;
    localparam int CTL_EVEN = 4;
    localparam int CTL_RATE_LO = 5;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TPER_RST = 8'h01;
    // ==========================================
    // Status field positions
    localparam int ST_PARITY_ERROR_FLAG = 7;
    localparam int ST_FRAME_ERROR_FLAG = 6;
    localparam int ST_OERR = 5;
    localparam int ST_RBFL = 4;
    localparam int ST_TEND = 3;
    localparam int ST_TBEP = 2;
    // ==========================================
    // Timing
    localparam longint CLK_HZ = 100_000_000;
    localparam longint BAUD_FAST = 76800;
    localparam int OVERSAMPLE = 16;
    localparam logic [12:0] TICK_DIV0 =
        13'(CLK_HZ / (BAUD_FAST * OVERSAMPLE));
    localparam logic [2:0] RATE_TIMER = 3'h6;
    localparam logic [2:0] RATE_SLOWEST = 3'h5;
    localparam logic [3:0] SMP_FIRST = 4'h7;
    localparam logic [3:0] SMP_LAST = 4'h9;
    localparam logic [3:0] TICK_LAST = 4'hf;
    // ==========================================
    // Types
    typedef enum logic {ASP_TX_IDLE, ASP_TX_SEND} asp_tx_st_t;
    typedef enum logic {ASP_RX_IDLE, ASP_RX_BITS} asp_rx_st_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } asp_bus_t;
endpackage

// >>> verif/asp_remote.sv
// Remote line partner: sends frames to the port and captures its frames
`timescale 1ns/10ps
module asp_remote (
    input wire logic clk,
    input wire logic tx_line,
    output logic rx_line
);
    int bitc = 16;
    bit pen = 1'b0;
    bit even = 1'b0;
    int got_q[$];
    logic [7:0] cd;
    logic cp;
    logic cok;

    initial rx_line = 1'b1;

    // ==========================================
    // Sender; bp/bs break parity/stop, gl upsets one sample of data bit 2
    task automatic send(input logic [7:0] d, input int bp, input int bs, input int gl);
        logic b;
        for (int n = 0; n < 10 + pen; n++) begin
            if (n == 0)
                b = 1'b0;
            else if (n < 9)
                b = d[n - 1];
            else if (n == 9 && pen)
                b = ^d ^ !even ^ bp[0];
            else
                b = !bs[0];
            for (int c = 0; c < bitc; c++) begin
                @(posedge clk);
                rx_line <= (gl != 0 && n == 3 && c == 7) ? !b : b;
            end
        end
        @(posedge clk);
        rx_line <= 1'b1;
        // Gap keeps the line high for two bit times before the next frame
        repeat (2 * bitc) @(posedge clk);
    endtask

    // ==========================================
    // Capture at mid-bit; only the first stop bit is judged
    always begin
        @(negedge tx_line);
        repeat (bitc / 2) @(posedge clk);
        cok = !tx_line;
        for (int i = 0; i < 8; i++) begin
            repeat (bitc) @(posedge clk);
            cd[i] = tx_line;
        end
        cp = 1'b0;
        if (pen) begin
            repeat (bitc) @(posedge clk);
            cp = tx_line;
        end
        repeat (bitc) @(posedge clk);
        got_q.push_back({22'h0, cok & tx_line, cp, cd});
    end
endmodule

// >>> verif/async_serial_port_rate_and_flags_tb_top.sv
// Bench: serial port checked against a flag model and the remote partner
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module async_serial_port_rate_and_flags_tb_top
    import asp_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    asp_bus_t bus = '0;
    logic [7:0] rdata;
    logic rx_line, tx_line, tx_interrupt, rx_interrupt;
    int err_count = 0;
    int checks_done = 0;
    int seed = 52;
    int cyc = 0;
    int irq_rx = 0;
    int m_rbuf = 0, m_rbfl = 0, m_parity_error_flag = 0, m_frame_error_flag = 0, m_oerr = 0, m_rxe = 1;

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (rx_interrupt === 1'b1)
            irq_rx++;
    end

    asp_top u_asp_top (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .rx_line(rx_line),
        .tx_line(tx_line), .tx_interrupt(tx_interrupt), .rx_interrupt(rx_interrupt));
    asp_remote u_asp_remote (.clk(clk), .tx_line(tx_line), .rx_line(rx_line));

    // ==========================================
    // Bus and wait helpers
    task automatic close_out;
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input string nm, input int e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        `CHK(nm, e[7:0], rdata)
    endtask

    task automatic wait_tx;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (n < 20000 && tx_interrupt !== 1'b1);
        if (n == 20000) begin
            err_count++;
            close_out();
        end
    endtask

    // ==========================================
    // Two back-to-back bytes; start-to-start time gives the frame length
    task automatic tx_cfg(input int rate, input int per, input int st2, input int pe, input int ev);
        logic [7:0] d [2];
        int div, t0, nb, v;
        div = (rate == 6) ? per : int'(TICK_DIV0);
        nb = 10 + pe + st2;
        u_asp_remote.bitc = 16 * div;
        u_asp_remote.pen = pe[0];
        u_asp_remote.even = ev[0];
        wr(ADDR_TPER, per[7:0]);
        wr(ADDR_CTRL, {rate[2:0], ev[0], pe[0], st2[0], 2'b01});
        rd(ADDR_TPER, "period", per);
        for (int i = 0; i < 2; i++) begin
            d[i] = 8'($random(seed));
            rd(ADDR_STAT, "status before load", i ? 8'h04 : 8'h0c);
            wr(ADDR_BUF, d[i]);
            wait_tx();
            v = cyc - t0 - 16 * div * nb;
            if (i)
                `CHK("frame time", 1'b1, v >= 0 && v <= div)
            t0 = cyc;
        end
        repeat (16 * div * (nb + 1)) @(posedge clk);
        rd(ADDR_STAT, "status after frames", 8'h0c);
        for (int i = 0; i < 2; i++) begin
            v = u_asp_remote.got_q.pop_front();
            `CHK("line frame", {1'b1, pe ? ^d[i] ^ !ev[0] : 1'b0, d[i]}, v[9:0])
        end
    endtask

    // ==========================================
    // Receive model: load, overrun or ignore, as the flags stand
    task automatic rx_frame(input int bp, input int bs, input int gl, input string nm);
        logic [7:0] d;
        int c0;
        d = 8'($random(seed));
        c0 = irq_rx;
        u_asp_remote.send(d, bp, bs, gl);
        repeat (4) @(posedge clk);
        if (!m_rxe || m_oerr)
            `CHK(nm, 0, irq_rx - c0)
        else if (m_rbfl) begin
            `CHK(nm, 0, irq_rx - c0)
            m_oerr = 1;
        end else begin
            `CHK(nm, 1, irq_rx - c0)
            m_rbuf = d;
            m_rbfl = 1;
            m_parity_error_flag = bp;
            m_frame_error_flag = bs;
        end
    endtask

    task automatic rx_read(input string nm);
        rd(ADDR_STAT, nm, {m_parity_error_flag[0], m_frame_error_flag[0], m_oerr[0], m_rbfl[0], 4'hc});
        rd(ADDR_BUF, "receive buffer", m_rbuf);
        m_parity_error_flag = 0;
        m_frame_error_flag = 0;
        m_oerr = 0;
        m_rbfl = 0;
        rd(ADDR_STAT, "status after clear", 8'h0c);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wr(ADDR_CTRL, 8'h01);
        wr(ADDR_BUF, 8'h55);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            `CHK("idle line", 1'b1, tx_line)
        end
        rd(ADDR_STAT, "reset status", 8'h0c);
        rd(8'h23, "unmapped", 0);
        tx_cfg(6, 1, 0, 0, 0);
        tx_cfg(6, 1, 1, 1, 0);
        tx_cfg(6, 1, 0, 1, 1);
        tx_cfg(6, 3, 1, 1, 1);
        tx_cfg(0, 1, 0, 0, 0);
        wr(ADDR_TPER, 8'h01);
        wr(ADDR_CTRL, {RATE_TIMER, 5'b01010});
        u_asp_remote.bitc = 16;
        u_asp_remote.pen = 1'b1;
        u_asp_remote.even = 1'b0;
        rx_frame(0, 0, 1, "rx glitch");
        rx_read("rx status");
        wr(ADDR_CTRL, {RATE_TIMER, 5'b11010});
        u_asp_remote.even = 1'b1;
        rx_frame(1, 0, 0, "rx parity");
        rx_read("parity status");
        rx_frame(0, 1, 0, "rx stop");
        rx_read("stop status");
        rx_frame(0, 0, 0, "rx load");
        rd(ADDR_STAT, "status before overrun", 8'h1c);
        rx_frame(0, 0, 0, "rx overrun");
        rd(ADDR_BUF, "kept buffer", m_rbuf);
        m_rbfl = 0;
        rd(ADDR_STAT, "overrun kept", 8'h2c);
        rx_frame(0, 0, 0, "rx blocked");
        rx_read("overrun status");
        fork
            rx_frame(0, 0, 0, "rx finishes");
            begin
                repeat (60) @(posedge clk);
                wr(ADDR_CTRL, {RATE_TIMER, 5'b11000});
            end
        join
        m_rxe = 0;
        rx_read("late disable");
        rx_frame(0, 0, 0, "rx disabled");
        close_out();
    end
endmodule
